// ---- hdl/dcm_pkg.sv ----
// Constants and field layout of the converter configuration and monitor-select block
// Function
// [RL1] Select bits 00 reach special-function commands by address
// [RL2] Configuration register is command 01100, data field
// [RL3] Read/write bit zero writes, one reads back
// [RL4] Bit 13: power-down output high-Z or load
// [RL5] Bit 12 picks internal reference 2.5/1.25 V
// [RL6] Bit 11 boosts output amplifier bias
// [RL7] Bit 10 picks internal or external reference
// [RL8] Internal reference level follows bit 12
// [RL9] Bit 9 enables monitor routing
// [RL10] Monitor disabled holds monitor output high-Z
// [RL11] Bit 8 thermal trip powers down amplifiers
// [RL12] Soft power-up recovers only once cool
// [RL13] Bits 7, 6, 1, 0 ignored
// [RL14] Bits 5..2 enable toggle groups
// [RL15] Group n covers channels 8n..8n+7
// [RL16] Enabled channels alternate A/B on load
// [RL17] Monitor select is command 01010, top six bits
// [RL18] Host enables monitor before selecting channel
// [RL19] Codes 0-31 channels, 32-35 external inputs
// [RL20] Code 63 makes monitor output high-Z
// [RL21] Readback returns written defined bits, unused zero
package dcm_pkg;

    // ****************************************************************
    // Command word layout
    // ****************************************************************
    localparam int CFG_W   = 14;
    localparam int DATA_W  = 14;
    localparam int CA_W    = 5;
    localparam int MON_W   = 6;
    localparam int CHAN_N  = 32;
    localparam int GROUP_N = 4;
    localparam int GROUP_SIZE = 8;
    localparam int MON_FIELD_LO = 8;
    localparam int CHAN_IDX_W = 5;
    localparam int EXT_IDX_W  = 2;

    localparam logic [1:0]      REGSEL_SFR     = 2'h0;
    localparam logic [CA_W-1:0] SFR_CONFIG     = 5'h0C;
    localparam logic [CA_W-1:0] SFR_MONITOR    = 5'h0A;
    localparam logic [CA_W-1:0] SFR_POWER_DOWN = 5'h08;
    localparam logic [CA_W-1:0] SFR_POWER_UP   = 5'h09;
    localparam logic [CA_W-1:0] SFR_SOFT_RESET = 5'h0F;

    // ****************************************************************
    // Configuration register fields
    // ****************************************************************
    localparam int CFG_PD_LOAD   = 13;
    localparam int CFG_REF_LEVEL = 12;
    localparam int CFG_BOOST     = 11;
    localparam int CFG_INT_REF   = 10;
    localparam int CFG_MON_EN    = 9;
    localparam int CFG_THERM_EN  = 8;
    localparam int CFG_TOGGLE_LO = 2;

    localparam logic [CFG_W-1:0] CFG_DEFINED_MASK = 14'h3F3C;
    localparam logic [CFG_W-1:0] CFG_RESET_BASE   = 14'h2000;
    localparam logic [CFG_W-1:0] CFG_REF_BIT      = 14'h1000;

    // ****************************************************************
    // Monitor address codes
    // ****************************************************************
    localparam logic [MON_W-1:0] MON_EXT_BASE = 6'h20;
    localparam logic [MON_W-1:0] MON_EXT_LAST = 6'h23;
    localparam logic [MON_W-1:0] MON_TRISTATE = 6'h3F;

endpackage : dcm_pkg

// ---- hdl/dcm_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dcm_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] asyncIn,
    input  wire logic [W-1:0] resetLevel,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } dcm_sync_t;

    dcm_sync_t s_r;
    dcm_sync_t s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.stage1 = asyncIn;
        s_nxt.stage2 = s_r.stage1;
    end

    // Reset to the pin's idle level so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '{stage1: resetLevel, stage2: resetLevel};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.stage2;
endmodule : dcm_sync

// ---- hdl/dcm_toggle.sv ----
// Per-channel A/B toggle selection driven by the load strobe
`timescale 1ns/1ps
module dcm_toggle
    import dcm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              loadPulse,
    input  wire logic [GROUP_N-1:0] groupEn,
    output logic      [CHAN_N-1:0]  useB
);
    typedef struct packed {
        logic [CHAN_N-1:0] useB;
    } dcm_toggle_t;

    dcm_toggle_t       s_r;
    dcm_toggle_t       s_nxt;
    logic [CHAN_N-1:0] togNext;

    // A disabled group falls back to the A register
    for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
        assign togNext[i] = !groupEn[i / GROUP_SIZE] ? 1'b0 :       // RL15
                            (loadPulse ? ~s_r.useB[i] : s_r.useB[i]); // RL16
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.useB = togNext;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign useB = s_r.useB;
endmodule : dcm_toggle

// ---- hdl/dcm_control.sv ----
// Configuration register, power control and monitor select of the converter
`timescale 1ns/1ps
module dcm_control
    import dcm_pkg::*;
#(
    parameter logic REF_DEFAULT_HIGH = 1'b1
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               cmdValid,
    input  wire logic               cmdReadWrite,
    input  wire logic               regSelectHi,
    input  wire logic               regSelectLo,
    input  wire logic [CA_W-1:0]    commandAddress,
    input  wire logic [DATA_W-1:0]  cmdData,
    input  wire logic               overTempPin,
    input  wire logic               loadOutputs_n,
    output logic      [DATA_W-1:0]  readData,
    output logic                    readValid,
    output logic                    pdOutputLoadSel,
    output logic                    refLevelSel,
    output logic                    ampBoostEn,
    output logic                    internalRefEn,
    output logic                    refOutputHigh,
    output logic                    monitorEn,
    output logic                    thermalShutdownEn,
    output logic      [GROUP_N-1:0] toggleGroupEn,
    output logic                    ampPowerDown,
    output logic                    thermalTripped,
    output logic                    monitorRouteChan,
    output logic      [CHAN_IDX_W-1:0] monitorChannel,
    output logic                    monitorRouteExt,
    output logic      [EXT_IDX_W-1:0]  externalMonitorSel,
    output logic                    monitorOutputOe,
    output logic                    channelLoad,
    output logic      [CHAN_N-1:0]  channelSelectB
);
    localparam logic [CFG_W-1:0] CFG_DEFAULT =
        CFG_RESET_BASE | (REF_DEFAULT_HIGH ? CFG_REF_BIT : '0);

    typedef struct packed {
        logic [CFG_W-1:0]      cfg;
        logic [MON_W-1:0]      monSel;
        logic                  softPd;
        logic                  thermTrip;
        logic                  loadPrev;
        logic                  loadPulse;
        logic [DATA_W-1:0]     rdData;
        logic                  rdValid;
        logic                  monChan;
        logic                  monExt;
        logic                  monOe;
        logic [CHAN_IDX_W-1:0] monIdx;
        logic [EXT_IDX_W-1:0]  extIdx;
    } dcm_core_t;

    localparam dcm_core_t CORE_RESET = '{
        cfg:       CFG_DEFAULT,
        monSel:    MON_TRISTATE,
        softPd:    1'b0,
        thermTrip: 1'b0,
        loadPrev:  1'b1,
        loadPulse: 1'b0,
        rdData:    '0,
        rdValid:   1'b0,
        monChan:   1'b0,
        monExt:    1'b0,
        monOe:     1'b0,
        monIdx:    '0,
        extIdx:    '0
    };

    dcm_core_t  s_r;
    dcm_core_t  s_nxt;
    logic [1:0] pinSync;
    logic       overTemp;
    logic       loadLevel;
    logic       isSfr;
    logic       powered;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    dcm_sync #(
        .W (2)
    ) u_sync (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .asyncIn    ({overTempPin, loadOutputs_n}),
        .resetLevel (2'h1),
        .syncOut    (pinSync)
    );

    assign overTemp  = pinSync[1];
    assign loadLevel = pinSync[0];

    // ****************************************************************
    // Command decode and state update
    // ****************************************************************
    assign isSfr   = cmdValid && ({regSelectHi, regSelectLo} == REGSEL_SFR); // RL1
    assign powered = !(s_r.softPd || s_r.thermTrip);

    always_comb begin
        s_nxt           = s_r;
        s_nxt.rdValid   = 1'b0;
        s_nxt.loadPrev  = loadLevel;
        s_nxt.loadPulse = s_r.loadPrev && !loadLevel;
        if (isSfr) begin
            case (commandAddress)
                SFR_CONFIG: begin                                     // RL2
                    if (cmdReadWrite) begin                           // RL3
                        s_nxt.rdData  = s_r.cfg & CFG_DEFINED_MASK;   // RL21
                        s_nxt.rdValid = 1'b1;
                    end else if (powered) begin
                        s_nxt.cfg = cmdData & CFG_DEFINED_MASK;       // RL13
                    end
                end
                SFR_MONITOR: begin
                    if (!cmdReadWrite && powered) begin
                        s_nxt.monSel = cmdData[DATA_W-1:MON_FIELD_LO]; // RL17
                    end
                end
                SFR_POWER_DOWN: begin
                    if (!cmdReadWrite) begin
                        s_nxt.softPd = 1'b1;
                    end
                end
                SFR_POWER_UP: begin
                    if (!cmdReadWrite) begin
                        s_nxt.softPd = 1'b0;
                        if (!overTemp) begin
                            s_nxt.thermTrip = 1'b0;                   // RL12
                        end
                    end
                end
                SFR_SOFT_RESET: begin
                    if (!cmdReadWrite) begin
                        s_nxt.cfg    = CFG_DEFAULT;
                        s_nxt.monSel = MON_TRISTATE;
                    end
                end
                default: begin
                end
            endcase
        end
        // Trip is applied after the power-up clear so a hot die stays down
        if (s_r.cfg[CFG_THERM_EN] && overTemp) begin
            s_nxt.thermTrip = 1'b1;                                   // RL11
        end
        // Monitor routing decoded one cycle behind the select
        s_nxt.monChan = s_r.monSel < MON_EXT_BASE;                    // RL19
        s_nxt.monExt  = (s_r.monSel >= MON_EXT_BASE) && (s_r.monSel <= MON_EXT_LAST);
        s_nxt.monIdx  = s_r.monSel[CHAN_IDX_W-1:0];
        s_nxt.extIdx  = s_r.monSel[EXT_IDX_W-1:0];
        // Undefined codes also release the pin rather than route garbage
        s_nxt.monOe   = s_r.cfg[CFG_MON_EN] && (s_r.monSel <= MON_EXT_LAST); // RL9 RL10 RL20
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_r <= CORE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Toggle channel selection
    // ****************************************************************
    dcm_toggle u_toggle (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .loadPulse (s_r.loadPulse),
        .groupEn   (s_r.cfg[CFG_TOGGLE_LO +: GROUP_N]),              // RL14
        .useB      (channelSelectB)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readData          = s_r.rdData;
    assign readValid         = s_r.rdValid;
    assign pdOutputLoadSel   = s_r.cfg[CFG_PD_LOAD];                  // RL4
    assign refLevelSel       = s_r.cfg[CFG_REF_LEVEL];                // RL5
    assign ampBoostEn        = s_r.cfg[CFG_BOOST];                    // RL6
    assign internalRefEn     = s_r.cfg[CFG_INT_REF];                  // RL7
    assign refOutputHigh     = s_r.cfg[CFG_INT_REF] && s_r.cfg[CFG_REF_LEVEL]; // RL8
    assign monitorEn         = s_r.cfg[CFG_MON_EN];
    assign thermalShutdownEn = s_r.cfg[CFG_THERM_EN];
    assign toggleGroupEn     = s_r.cfg[CFG_TOGGLE_LO +: GROUP_N];
    assign ampPowerDown      = s_r.softPd || s_r.thermTrip;
    assign thermalTripped    = s_r.thermTrip;
    assign monitorRouteChan  = s_r.monOe && s_r.monChan;
    assign monitorChannel    = s_r.monIdx;
    assign monitorRouteExt   = s_r.monOe && s_r.monExt;
    assign externalMonitorSel = s_r.extIdx;
    assign monitorOutputOe   = s_r.monOe;
    assign channelLoad       = s_r.loadPulse;
endmodule : dcm_control

// ---- test/dcm_control_chk.sv ----
// Assertion checker bound to the configuration and monitor-select block
`timescale 1ns/1ps
module dcm_control_chk
    import dcm_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic                cmdValid,
    input wire logic                cmdReadWrite,
    input wire logic                regSelectHi,
    input wire logic                regSelectLo,
    input wire logic [CA_W-1:0]     commandAddress,
    input wire logic [DATA_W-1:0]   cmdData,
    input wire logic                overTempPin,
    input wire logic                readValid,
    input wire logic                refLevelSel,
    input wire logic                internalRefEn,
    input wire logic                refOutputHigh,
    input wire logic                monitorEn,
    input wire logic                thermalShutdownEn,
    input wire logic [GROUP_N-1:0]  toggleGroupEn,
    input wire logic                ampPowerDown,
    input wire logic                thermalTripped,
    input wire logic                monitorRouteChan,
    input wire logic [CHAN_IDX_W-1:0] monitorChannel,
    input wire logic                monitorOutputOe,
    input wire logic                channelLoad,
    input wire logic [CHAN_N-1:0]   channelSelectB
);
    // ********************
    // Decode helpers
    // ********************
    wire special_function_space = cmdValid && !regSelectHi && !regSelectLo;
    wire cfgWr = special_function_space && commandAddress == SFR_CONFIG && !cmdReadWrite;
    wire monWr = special_function_space && commandAddress == SFR_MONITOR && !cmdReadWrite;
    wire live = !ampPowerDown && !thermalTripped;
    wire [CHAN_N-1:0] grpMask = {{8{toggleGroupEn[3]}}, {8{toggleGroupEn[2]}},
                                 {8{toggleGroupEn[1]}}, {8{toggleGroupEn[0]}}};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (special_function_space && commandAddress == SFR_CONFIG && cmdReadWrite |=> readValid)
        else $error("config read not answered");
    a_write_cfg: assert property (cfgWr && live |=> toggleGroupEn == $past(cmdData[5:2])
        && monitorEn == $past(cmdData[9])) else $error("config write not applied");
    a_ref_follow: assert property (cfgWr && live |=>
        refOutputHigh == ($past(cmdData[10]) && $past(cmdData[12])))
        else $error("reference level wrong");
    a_mon_off: assert property (!monitorEn && !$past(monitorEn) |-> !monitorOutputOe)
        else $error("monitor driven while disabled");
    a_mon_hiz63: assert property (monWr && live && cmdData[13:8] == 6'h3F ##1 !special_function_space |-> ##1
        !monitorOutputOe) else $error("code 63 left monitor driven");
    a_mon_route: assert property (monWr && live && monitorEn && !cmdData[13] ##1 !special_function_space |-> ##1
        monitorRouteChan && monitorChannel == $past(cmdData[12:8], 2)) else $error("bad route");
    a_trip_set: assert property ((thermalShutdownEn && overTempPin)[*3] |-> ##3
        thermalTripped && ampPowerDown) else $error("no thermal shutdown");
    a_trip_cause: assert property (!thermalShutdownEn && !thermalTripped |=> !thermalTripped)
        else $error("trip while disabled");
    a_toggle_off: assert property ((channelSelectB & ~grpMask & ~$past(grpMask)) == 32'h0)
        else $error("disabled group selects B");
    a_toggle_flip: assert property (channelLoad && toggleGroupEn[0] |=>
        channelSelectB[0] != $past(channelSelectB[0])) else $error("channel did not toggle");

    c_read: cover property (readValid);
    c_trip: cover property (thermalTripped);
    c_route: cover property (monitorRouteChan);
    c_load: cover property (channelLoad && toggleGroupEn != 4'h0);
endmodule : dcm_control_chk

bind dcm_control dcm_control_chk i_chk (.*);

// ---- test/dcm_host.sv ----
// Host controller model that issues command words to the block
`timescale 1ns/1ps
module dcm_host
    import dcm_pkg::*;
(
    input  wire logic              core_clk,
    output logic                   cmdValid,
    output logic                   cmdReadWrite,
    output logic                   regSelectHi,
    output logic                   regSelectLo,
    output logic [CA_W-1:0]        commandAddress,
    output logic [DATA_W-1:0]      cmdData
);
    initial begin
        cmdValid = 1'b0;
        cmdReadWrite = 1'b0;
        {regSelectHi, regSelectLo} = 2'b11;
        commandAddress = 5'h00;
        cmdData = 14'h0000;
    end

    // ********************
    // One command word, one-cycle strobe
    // ********************
    task automatic send(input logic [1:0] sel, input logic rw, input logic [CA_W-1:0] addr,
                        input logic [DATA_W-1:0] data);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        {regSelectHi, regSelectLo} <= sel;
        cmdReadWrite <= rw;
        commandAddress <= addr;
        cmdData <= data;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        // Released lines must not keep the old word visible
        cmdReadWrite <= ~rw;
        commandAddress <= ~addr;
        cmdData <= ~data;
    endtask : send
endmodule : dcm_host

// ---- test/dcm_control_test.sv ----
// Self-checking testbench of the configuration and monitor-select block
`timescale 1ns/1ps
module dcm_control_test
    import dcm_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n, overTempPin, loadOutputs_n, cmdValid, cmdReadWrite, regSelectHi, regSelectLo;
    logic [CA_W-1:0] commandAddress;
    logic [DATA_W-1:0] cmdData, readData;
    logic readValid, pdOutputLoadSel, refLevelSel, ampBoostEn, internalRefEn, refOutputHigh;
    logic monitorEn, thermalShutdownEn, ampPowerDown, thermalTripped, monitorRouteChan;
    logic monitorRouteExt, monitorOutputOe, channelLoad;
    logic [GROUP_N-1:0] toggleGroupEn;
    logic [CHAN_IDX_W-1:0] monitorChannel;
    logic [EXT_IDX_W-1:0] externalMonitorSel;
    logic [CHAN_N-1:0] channelSelectB;
    logic [5:0] codes [7] = '{6'h00, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h3E, 6'h3F};
    int errCount = 0;
    int checksDone = 0;

    always #5 core_clk = ~core_clk;

    dcm_host i_host (.*);
    dcm_control i_dut (.*);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (errCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [CA_W-1:0] a, input logic [DATA_W-1:0] d);
        i_host.send(2'b00, 1'b0, a, d);
        settle(2);
    endtask : wr

    task automatic readCfg(input logic [DATA_W-1:0] exp);
        i_host.send(2'b00, 1'b1, SFR_CONFIG, 14'h0000);
        #1;
        check("readValid", readValid, 1'b1);
        check("readData", readData, exp);
    endtask : readCfg

    // Falling load edge, then wait for the pulse under a bound
    task automatic pulseLoad(input logic [CHAN_N-1:0] exp);
        int n;
        @(posedge core_clk);
        loadOutputs_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        loadOutputs_n <= 1'b1;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (channelLoad !== 1'b1 && n < 10);
        if (channelLoad !== 1'b1) begin
            errCount++;
            results();
        end
        settle(1);
        check("channelSelectB", channelSelectB, exp);
    endtask : pulseLoad

    initial begin
        rst_n = 1'b0;
        overTempPin = 1'b0;
        loadOutputs_n = 1'b1;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(4);
        // ********************
        // Reset values, readback and reference
        // ********************
        check("cfg", {pdOutputLoadSel, refLevelSel, ampBoostEn, internalRefEn, monitorEn,
                      thermalShutdownEn, toggleGroupEn}, 10'h300);
        check("monOe", monitorOutputOe, 1'b0);
        readCfg(14'h3000);
        wr(SFR_CONFIG, 14'h3FFF);
        readCfg(14'h3F3C);
        check("refHigh", refOutputHigh, 1'b1);
        wr(SFR_CONFIG, 14'h0400);
        check("refHigh", refOutputHigh, 1'b0);
        i_host.send(2'b11, 1'b0, SFR_CONFIG, 14'h3FFF);
        readCfg(14'h0400);
        i_host.send(2'b00, 1'b1, SFR_MONITOR, 14'h0000);
        #1;
        check("readValid", readValid, 1'b0);
        // ********************
        // Monitor routing, enabled first
        // ********************
        wr(SFR_CONFIG, 14'h0200);
        foreach (codes[i]) begin
            wr(SFR_MONITOR, {codes[i], 8'h5A});
            check("monOe", monitorOutputOe, codes[i] <= 6'h23);
            check("route", {monitorRouteChan, monitorRouteExt},
                  {codes[i] < 6'h20, codes[i] >= 6'h20 && codes[i] <= 6'h23});
            if (codes[i] <= 6'h23)
                check("monSel", (codes[i] < 6'h20) ? {27'h0, monitorChannel} :
                      {30'h0, externalMonitorSel}, (codes[i] < 6'h20) ? {27'h0, codes[i][4:0]} :
                      {30'h0, codes[i][1:0]});
        end
        wr(SFR_MONITOR, 14'h0500);
        wr(SFR_CONFIG, 14'h0000);
        check("monOe", monitorOutputOe, 1'b0);
        // ********************
        // Toggle groups
        // ********************
        wr(SFR_CONFIG, 14'h0024);
        pulseLoad(32'hFF00_00FF);
        pulseLoad(32'h0000_0000);
        wr(SFR_CONFIG, 14'h0018);
        pulseLoad(32'h00FF_FF00);
        // ********************
        // Thermal shutdown and recovery
        // ********************
        @(posedge core_clk);
        overTempPin <= 1'b1;
        settle(6);
        check("tripped", thermalTripped, 1'b0);
        wr(SFR_CONFIG, 14'h0100);
        settle(4);
        check("pd", {thermalTripped, ampPowerDown}, 2'b11);
        wr(SFR_POWER_UP, 14'h0000);
        check("pd", ampPowerDown, 1'b1);
        @(posedge core_clk);
        overTempPin <= 1'b0;
        settle(4);
        wr(SFR_POWER_UP, 14'h0000);
        check("pd", {thermalTripped, ampPowerDown}, 2'b00);
        // ********************
        // Soft power-down, soft reset, mid-run reset
        // ********************
        wr(SFR_POWER_DOWN, 14'h0000);
        check("pd", ampPowerDown, 1'b1);
        wr(SFR_CONFIG, 14'h0800);
        readCfg(14'h0100);
        wr(SFR_SOFT_RESET, 14'h0000);
        wr(SFR_POWER_UP, 14'h0000);
        check("pd", ampPowerDown, 1'b0);
        readCfg(14'h3000);
        wr(SFR_CONFIG, 14'h0A00);
        check("cfgOut", {pdOutputLoadSel, ampBoostEn, monitorEn}, 3'h3);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(1);
        check("rst", {ampBoostEn, monitorEn, monitorOutputOe, channelLoad}, 4'h0);
        readCfg(14'h3000);
        results();
    end
endmodule : dcm_control_test
